// ### cscirq_params.svh
// cscirq_params.svh: register indices, field positions and reset values
// of the card status change interrupt block.
// assumes: byte address of a register is four times its index.
`ifndef CSCIRQ_PARAMS_SVH
`define CSCIRQ_PARAMS_SVH

// ****************************************
// register indices (byte address = index * 4)
// ****************************************
`define CSCIRQ_IDX_GLOBAL   6'h1E
`define CSCIRQ_IDX_STATUS   6'h04
`define CSCIRQ_IDX_IRQ_CFG  6'h05
`define CSCIRQ_IDX_WIN_EN   6'h06
`define CSCIRQ_IDX_CLEAR    6'h3F

// ****************************************
// field positions
// ****************************************
`define CSCIRQ_POS_DETECT   3
`define CSCIRQ_POS_READY    2
`define CSCIRQ_POS_LOWBAT   1
`define CSCIRQ_POS_FAIL     0

// ****************************************
// reset values
// ****************************************
`define CSCIRQ_RST_GLOBAL   3'h0
`define CSCIRQ_RST_IRQ_CFG  8'h00
`define CSCIRQ_RST_WIN_EN   8'h00
`define CSCIRQ_RST_STATUS   4'h0
`define CSCIRQ_PIN_IDLE     6'h23

// ****************************************
// bus responses
// ****************************************
`define CSCIRQ_RESP_OKAY    2'h0
`define CSCIRQ_RESP_SLVERR  2'h2

`endif

// ### cscirq_pkg.sv
// cscirq_pkg.sv: types of the card status change interrupt block.
// assumes: cscirq_params.svh holds the numbers.
`default_nettype none
package cscirq_pkg;

  // ****************************************
  // register layouts
  // ****************************************
  typedef struct packed {
    logic       io_card;
    logic       ring_enable;
    logic       explicit_wb;
  } cscirq_glob_s;

  typedef struct packed {
    logic [3:0] irq_route_select;
    logic       detect_change_irq_enable;
    logic       ready_rise_irq_enable;
    logic       low_battery_irq_enable;
    logic       battery_fail_irq_enable;
  } cscirq_cfg_s;

  typedef struct packed {
    logic [1:0] io_window_enables;
    logic       reserved;
    logic [4:0] memory_window_enables;
  } cscirq_win_s;

  // card pins, active-low ones marked _b
  typedef struct packed {
    logic       card_change_ring_line_b;
    logic       battery_fail;
    logic       low_battery;
    logic       ready;
    logic       card_detect_pin_b_b;
    logic       card_detect_pin_a_b;
  } cscirq_pins_s;

  // ****************************************
  // state of the top module, all but card_addr_q
  // ****************************************
  typedef struct packed {
    logic         aw_full;
    logic [5:0]   aw_idx;
    logic         w_full;
    logic [7:0]   w_byte;
    logic         w_lane0;
    logic         bvalid;
    logic [1:0]   bresp;
    logic         rvalid;
    logic [7:0]   rdata;
    logic [1:0]   rresp;
    cscirq_glob_s glob;
    cscirq_cfg_s  cfg;
    cscirq_win_s  win;
    logic [3:0]   status;
    logic [4:0]   mem_en;
    logic [1:0]   io_en;
  } cscirq_state_s;

endpackage
`default_nettype wire

// ### cscirq_pin_sync.sv
// cscirq_pin_sync.sv: two-flop synchroniser with edge detect for card pins.
// assumes: pins are asynchronous to CLK_I; rise/fall look only at
// the second and third flops.
`timescale 1ns/100ps
`default_nettype none
module cscirq_pin_sync #(
  parameter int           W       = 6,
  parameter logic [W-1:0] RST_LVL = '0
) (
  input  wire logic         CLK_I,
  input  wire logic         RST_B_I,
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] lvl_o,
  output logic      [W-1:0] rise_o,
  output logic      [W-1:0] fall_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } cscirq_sync_s;

  cscirq_sync_s s_q;
  cscirq_sync_s s_d;

  always_comb
  begin
    s_d.s1 = pin_i;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
  end

  always_ff @(posedge CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      s_q <= {RST_LVL, RST_LVL, RST_LVL};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign lvl_o  = s_q.s2;
  assign rise_o = s_q.s2 & ~s_q.s3;
  assign fall_o = ~s_q.s2 & s_q.s3;

endmodule // cscirq_pin_sync
`default_nettype wire

// ### cscirq_top.sv
// cscirq_top.sv: card status change interrupt logic with AXI4-Lite
// register access, irq steering and window enable gating.
// assumes: card pins asynchronous; window hit inputs on CLK_I.
//
// How it works
// - memory card fail bit set on battery dead
// - I/O fail bit: ring line low, ring off
// - config register at index 05: route, enables
// - route code picks one irq line
// - route, detect and ready enables reset zero
// - detect pin change raises when enabled
// - ready rising edge raises when enabled
// - low battery raises, memory cards only
// - fail enable gates battery dead / ring
// - status reads zero where enable is zero
// - explicit mode: write one clears bit
// - implicit mode: status read clears bits
// - window enables gate card enables, address
`timescale 1ns/100ps
`include "cscirq_params.svh"
`default_nettype none
module cscirq_top
  import cscirq_pkg::*;
#(
  parameter int CARD_ADDR_W = 26
) (
  input  wire logic                   CLK_I,
  input  wire logic                   RST_B_I,
  input  wire logic [7:0]             S_AXI_AWADDR_I,
  input  wire logic                   S_AXI_AWVALID_I,
  output logic                        S_AXI_AWREADY_O,
  input  wire logic [31:0]            S_AXI_WDATA_I,
  input  wire logic [3:0]             S_AXI_WSTRB_I,
  input  wire logic                   S_AXI_WVALID_I,
  output logic                        S_AXI_WREADY_O,
  output logic [1:0]                  S_AXI_BRESP_O,
  output logic                        S_AXI_BVALID_O,
  input  wire logic                   S_AXI_BREADY_I,
  input  wire logic [7:0]             S_AXI_ARADDR_I,
  input  wire logic                   S_AXI_ARVALID_I,
  output logic                        S_AXI_ARREADY_O,
  output logic [31:0]                 S_AXI_RDATA_O,
  output logic [1:0]                  S_AXI_RRESP_O,
  output logic                        S_AXI_RVALID_O,
  input  wire logic                   S_AXI_RREADY_I,
  input  wire logic                   CARD_DETECT_PIN_A_B_I,
  input  wire logic                   CARD_DETECT_PIN_B_B_I,
  input  wire logic                   CARD_READY_I,
  input  wire logic                   LOW_BATTERY_I,
  input  wire logic                   BATTERY_FAIL_I,
  input  wire logic                   CARD_CHANGE_RING_LINE_B_I,
  input  wire logic [4:0]             MEM_HIT_I,
  input  wire logic [1:0]             IO_HIT_I,
  input  wire logic [CARD_ADDR_W-1:0] MEM_CARD_ADDR_I,
  output logic [4:0]                  CARD_MEM_EN_O,
  output logic [1:0]                  CARD_IO_EN_O,
  output logic [CARD_ADDR_W-1:0]      CARD_ADDR_O,
  output logic                        IRQ_O,
  output logic [15:0]                 IRQ_LINE_O,
  output logic [15:0]                 IRQ_LINE_OE_O
);

  // ****************************************
  // decoders
  // ****************************************
  function automatic logic [15:0] route_decode(input logic [3:0] code);
    logic [15:0] line;
    line = 16'h0000;
    unique case (code)
      4'h3:    line = 16'h0008;
      4'h4:    line = 16'h0010;
      4'h5:    line = 16'h0020;
      4'h7:    line = 16'h0080;
      4'h9:    line = 16'h0200;
      4'hA:    line = 16'h0400;
      4'hB:    line = 16'h0800;
      4'hC:    line = 16'h1000;
      4'hE:    line = 16'h4000;
      4'hF:    line = 16'h8000;
      default: line = 16'h0000;
    endcase
    return line;
  endfunction

  function automatic logic idx_mapped(input logic [5:0] idx);
    return (idx == `CSCIRQ_IDX_GLOBAL) || (idx == `CSCIRQ_IDX_STATUS) ||
           (idx == `CSCIRQ_IDX_IRQ_CFG) || (idx == `CSCIRQ_IDX_WIN_EN) ||
           (idx == `CSCIRQ_IDX_CLEAR);
  endfunction

  // ****************************************
  // card pins
  // ****************************************
  cscirq_pins_s pins_raw;
  cscirq_pins_s pins_rise;
  cscirq_pins_s pins_fall;

  assign pins_raw = '{card_change_ring_line_b: CARD_CHANGE_RING_LINE_B_I,
                      battery_fail:            BATTERY_FAIL_I,
                      low_battery:             LOW_BATTERY_I,
                      ready:                   CARD_READY_I,
                      card_detect_pin_b_b:     CARD_DETECT_PIN_B_B_I,
                      card_detect_pin_a_b:     CARD_DETECT_PIN_A_B_I};

  cscirq_pin_sync #(
    .W       (6),
    .RST_LVL (`CSCIRQ_PIN_IDLE)
  ) u_pin_sync (
    .CLK_I   (CLK_I),
    .RST_B_I (RST_B_I),
    .pin_i   (pins_raw),
    .lvl_o   (),
    .rise_o  (pins_rise),
    .fall_o  (pins_fall)
  );

  // ****************************************
  // state and event sources
  // ****************************************
  cscirq_state_s s_q;
  cscirq_state_s s_d;
  logic [CARD_ADDR_W-1:0] card_addr_q;
  logic [CARD_ADDR_W-1:0] card_addr_d;
  logic [3:0]             en;
  logic [3:0]             ev;
  logic [3:0]             set;
  logic [3:0]             clr;
  logic                   pending;
  logic                   do_write;
  logic                   ar_take;
  logic [5:0]             ar_idx;
  logic [4:0]             mem_open;

  assign en = s_q.cfg[3:0];

  assign ev[`CSCIRQ_POS_DETECT] = pins_rise.card_detect_pin_a_b | pins_fall.card_detect_pin_a_b |
                                  pins_rise.card_detect_pin_b_b | pins_fall.card_detect_pin_b_b;
  assign ev[`CSCIRQ_POS_READY]  = pins_rise.ready;
  assign ev[`CSCIRQ_POS_LOWBAT] = ~s_q.glob.io_card & pins_rise.low_battery;
  // I/O card ring line pulled low
  assign ev[`CSCIRQ_POS_FAIL]   = s_q.glob.io_card ?
                                  (~s_q.glob.ring_enable & pins_fall.card_change_ring_line_b) :
                                  pins_rise.battery_fail;

  assign set = ev & en;

  // interrupt held while an enabled bit is set
  assign pending = |(s_q.status & en);

  assign do_write = s_q.aw_full & s_q.w_full & ~s_q.bvalid;
  assign ar_take  = S_AXI_ARVALID_I & ~s_q.rvalid;
  assign ar_idx   = S_AXI_ARADDR_I[7:2];
  assign mem_open = MEM_HIT_I & s_q.win.memory_window_enables;

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    s_d         = s_q;
    clr         = 4'h0;
    card_addr_d = card_addr_q;

    if (S_AXI_AWVALID_I && !s_q.aw_full)
    begin
      s_d.aw_full = 1'b1;
      s_d.aw_idx  = S_AXI_AWADDR_I[7:2];
    end
    if (S_AXI_WVALID_I && !s_q.w_full)
    begin
      s_d.w_full  = 1'b1;
      s_d.w_byte  = S_AXI_WDATA_I[7:0];
      s_d.w_lane0 = S_AXI_WSTRB_I[0];
    end
    if (s_q.bvalid && S_AXI_BREADY_I)
    begin
      s_d.bvalid = 1'b0;
    end

    if (do_write)
    begin
      s_d.aw_full = 1'b0;
      s_d.w_full  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = idx_mapped(s_q.aw_idx) ? `CSCIRQ_RESP_OKAY : `CSCIRQ_RESP_SLVERR;
      if (s_q.w_lane0)
      begin
        unique case (s_q.aw_idx)
          `CSCIRQ_IDX_GLOBAL:  s_d.glob = s_q.w_byte[2:0];
          // in explicit mode, write one to a set bit acknowledges it
          `CSCIRQ_IDX_STATUS:  clr = s_q.glob.explicit_wb ? s_q.w_byte[3:0] : 4'h0;
          `CSCIRQ_IDX_IRQ_CFG: s_d.cfg = s_q.w_byte;
          // window enables, bit 5 held zero
          `CSCIRQ_IDX_WIN_EN:  s_d.win = {s_q.w_byte[7:6], 1'b0, s_q.w_byte[4:0]};
          `CSCIRQ_IDX_CLEAR:   clr = s_q.w_byte[3:0];
          default:             clr = 4'h0;
        endcase
      end
    end

    if (s_q.rvalid && S_AXI_RREADY_I)
    begin
      s_d.rvalid = 1'b0;
    end
    if (ar_take)
    begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = idx_mapped(ar_idx) ? `CSCIRQ_RESP_OKAY : `CSCIRQ_RESP_SLVERR;
      unique case (ar_idx)
        `CSCIRQ_IDX_GLOBAL:  s_d.rdata = {5'h00, s_q.glob};
        `CSCIRQ_IDX_STATUS:
        begin
          s_d.rdata = {4'h0, s_q.status & en};
          if (!s_q.glob.explicit_wb)
          begin
            clr = clr | (s_q.status & en);
          end
        end
        `CSCIRQ_IDX_IRQ_CFG: s_d.rdata = s_q.cfg;
        `CSCIRQ_IDX_WIN_EN:  s_d.rdata = s_q.win;
        default:             s_d.rdata = 8'h00;
      endcase
    end

    // a source firing in the clearing cycle stays set
    s_d.status = (s_q.status & ~clr) | set;

    s_d.mem_en = mem_open;
    s_d.io_en  = IO_HIT_I & s_q.win.io_window_enables;
    if (|mem_open)
    begin
      card_addr_d = MEM_CARD_ADDR_I;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      s_q         <= '0;
      s_q.cfg     <= `CSCIRQ_RST_IRQ_CFG;
      s_q.win     <= `CSCIRQ_RST_WIN_EN;
      s_q.glob    <= `CSCIRQ_RST_GLOBAL;
      s_q.status  <= `CSCIRQ_RST_STATUS;
      card_addr_q <= '0;
    end
    else
    begin
      s_q         <= s_d;
      card_addr_q <= card_addr_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign S_AXI_AWREADY_O = ~s_q.aw_full;
  assign S_AXI_WREADY_O  = ~s_q.w_full;
  assign S_AXI_BVALID_O  = s_q.bvalid;
  assign S_AXI_BRESP_O   = s_q.bresp;
  assign S_AXI_ARREADY_O = ~s_q.rvalid;
  assign S_AXI_RVALID_O  = s_q.rvalid;
  assign S_AXI_RDATA_O   = {24'h000000, s_q.rdata};
  assign S_AXI_RRESP_O   = s_q.rresp;
  assign CARD_MEM_EN_O   = s_q.mem_en;
  assign CARD_IO_EN_O    = s_q.io_en;
  assign CARD_ADDR_O     = card_addr_q;
  assign IRQ_O           = pending;

  // reserved or zero code leaves lines floating
  assign IRQ_LINE_OE_O   = route_decode(s_q.cfg.irq_route_select);
  assign IRQ_LINE_O      = IRQ_LINE_OE_O & {16{pending}};

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RST_B_I);

  a_detect_sets_flag: assert property (
    ev[`CSCIRQ_POS_DETECT] && en[`CSCIRQ_POS_DETECT] |=> s_q.status[`CSCIRQ_POS_DETECT] ##0 IRQ_O)
    else $error("detect change lost");

  a_detect_off_quiet: assert property (
    !en[`CSCIRQ_POS_DETECT] && !s_q.status[`CSCIRQ_POS_DETECT] |=> !s_q.status[`CSCIRQ_POS_DETECT])
    else $error("disabled detect set status");

  a_ready_rise_flag: assert property (
    pins_rise.ready && en[`CSCIRQ_POS_READY] |=> s_q.status[`CSCIRQ_POS_READY])
    else $error("ready rise lost");

  a_lowbat_memory_only: assert property (
    s_q.glob.io_card && $stable(s_q.glob.io_card) && !s_q.status[`CSCIRQ_POS_LOWBAT]
    |=> !s_q.status[`CSCIRQ_POS_LOWBAT])
    else $error("low battery set on I/O card");

  a_mem_fail_flag: assert property (
    !s_q.glob.io_card && pins_rise.battery_fail && en[`CSCIRQ_POS_FAIL] |=> s_q.status[`CSCIRQ_POS_FAIL])
    else $error("battery dead lost");

  a_ring_gated: assert property (
    s_q.glob.io_card && s_q.glob.ring_enable && !s_q.status[`CSCIRQ_POS_FAIL]
    |=> !s_q.status[`CSCIRQ_POS_FAIL])
    else $error("fail bit set with ring enabled");

  a_io_fail_flag: assert property (
    s_q.glob.io_card && !s_q.glob.ring_enable && pins_fall.card_change_ring_line_b && en[`CSCIRQ_POS_FAIL]
    |=> s_q.status[`CSCIRQ_POS_FAIL])
    else $error("ring line low lost");

  a_read_masked: assert property (
    ar_take && ar_idx == `CSCIRQ_IDX_STATUS |=> S_AXI_RVALID_O && (S_AXI_RDATA_O[3:0] & ~$past(en)) == 4'h0)
    else $error("disabled status bit read as one");

  a_read_clears: assert property (
    ar_take && ar_idx == `CSCIRQ_IDX_STATUS && !s_q.glob.explicit_wb && set == 4'h0 && !do_write
    |=> (s_q.status & $past(s_q.status) & $past(en)) == 4'h0)
    else $error("status read did not clear");

  a_explicit_keeps: assert property (
    s_q.glob.explicit_wb && ar_take && !do_write |=> s_q.status == ($past(s_q.status) | $past(set)))
    else $error("explicit mode read cleared status");

  a_irq_steered: assert property (
    s_q.cfg.irq_route_select == 4'hE && pending |-> IRQ_LINE_O == 16'h4000 && IRQ_LINE_OE_O == 16'h4000)
    else $error("irq 14 not steered");

  a_reserved_float: assert property (
    s_q.cfg.irq_route_select inside {4'h0, 4'h1, 4'h2, 4'h6, 4'h8, 4'hD} |-> IRQ_LINE_OE_O == 16'h0000)
    else $error("reserved route drives a line");

  a_window_gate: assert property (
    1'b1 |=> (CARD_MEM_EN_O & ~$past(s_q.win.memory_window_enables)) == 5'h00)
    else $error("card enable through closed window");

endmodule // cscirq_top
`default_nettype wire

// ### cscirq_card_model.sv
// cscirq_card_model.sv: behavioural PC card driving the status pins.
// assumes: only the bench's main thread calls drive().
`timescale 1ns/100ps
`include "cscirq_params.svh"
`default_nettype none
module cscirq_card_model
  import cscirq_pkg::*;
(
  input  wire logic        CLK_I,
  output var cscirq_pins_s pins_o
);
  // empty socket: detect and ring lines pulled up, the rest low
  cscirq_pins_s pins_q = `CSCIRQ_PIN_IDLE;
  assign pins_o = pins_q;

  // pins move just after an edge, never on it
  task automatic drive(input cscirq_pins_s v);
    @(posedge CLK_I);
    pins_q <= v;
  endtask
endmodule // cscirq_card_model
`default_nettype wire

// ### cscirq_tb.sv
// cscirq_tb.sv: self-checking bench of the card status change block.
// assumes: AXI4-Lite master in this file, card pins from the card model.
`timescale 1ns/100ps
`include "cscirq_params.svh"
`default_nettype none
module testbench
  import cscirq_pkg::*;
;
  logic         clk = 1'b0;
  logic         rst_b = 1'b0;
  logic [7:0]   awaddr = 8'h00;
  logic [7:0]   araddr = 8'h00;
  logic         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0]  wdata = 32'h00000000;
  logic [3:0]   wstrb = 4'h0;
  logic         awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]   bresp, rresp;
  logic [31:0]  rdata;
  logic [4:0]   mem_hit = 5'h00;
  logic [4:0]   mem_en;
  logic [1:0]   io_hit = 2'h0;
  logic [1:0]   io_en;
  logic [25:0]  maddr = 26'h0000000;
  logic [25:0]  caddr;
  logic [15:0]  irq_line, irq_oe;
  cscirq_pins_s pins;
  cscirq_pins_s p = `CSCIRQ_PIN_IDLE;
  int           fail_count = 0;
  int           n_checks = 0;
  int           cycles = 0;

  always #10 clk = ~clk;

  cscirq_card_model card (.CLK_I(clk), .pins_o(pins));

  cscirq_top dut (
    .CLK_I(clk), .RST_B_I(rst_b),
    .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
    .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready),
    .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
    .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
    .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready),
    .CARD_DETECT_PIN_A_B_I(pins.card_detect_pin_a_b), .CARD_DETECT_PIN_B_B_I(pins.card_detect_pin_b_b),
    .CARD_READY_I(pins.ready), .LOW_BATTERY_I(pins.low_battery), .BATTERY_FAIL_I(pins.battery_fail),
    .CARD_CHANGE_RING_LINE_B_I(pins.card_change_ring_line_b),
    .MEM_HIT_I(mem_hit), .IO_HIT_I(io_hit), .MEM_CARD_ADDR_I(maddr),
    .CARD_MEM_EN_O(mem_en), .CARD_IO_EN_O(io_en), .CARD_ADDR_O(caddr),
    .IRQ_O(irq), .IRQ_LINE_O(irq_line), .IRQ_LINE_OE_O(irq_oe)
  );

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic final_report();
    if (fail_count == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge clk);
      aw_ok = aw_ok || (awvalid && awready);
      w_ok = w_ok || (wvalid && wready);
      awvalid <= awvalid && !awready;
      wvalid <= wvalid && !wready;
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", 32'(er), 32'(bresp));
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk("rdata", {24'h000000, ed}, rdata);
    chk("rresp", 32'(er), 32'(rresp));
  endtask

  // a pin event needs three edges to land; six leaves margin
  task automatic pin();
    card.drive(p);
    repeat (6) @(posedge clk);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_map();
    rd(8'h14, 8'h00, 2'h0);
    rd(8'h18, 8'h00, 2'h0);
    rd(8'h10, 8'h00, 2'h0);
    chk("irq_oe", 32'h0, 32'(irq_oe));
    rd(8'h20, 8'h00, 2'h2);
    wr(8'h20, 8'hFF, 2'h2);
  endtask

  task automatic t_route();
    logic [15:0] e;
    for (int c = 0; c < 16; c++)
    begin
      e = (c inside {3, 4, 5, 7, 9, 10, 11, 12, 14, 15}) ? 16'h0001 << c : 16'h0000;
      wr(8'h14, {c[3:0], 4'h0}, 2'h0);
      rd(8'h14, {c[3:0], 4'h0}, 2'h0);
      chk("irq_oe", 32'(e), 32'(irq_oe));
      chk("irq_line", 32'h0, 32'(irq_line));
    end
  endtask

  task automatic t_detect();
    wr(8'h78, 8'h01, 2'h0);
    wr(8'h14, 8'h50, 2'h0);
    p.card_detect_pin_a_b = 1'b0;
    p.card_detect_pin_b_b = 1'b0;
    pin();
    rd(8'h10, 8'h00, 2'h0);
    wr(8'h14, 8'h58, 2'h0);
    chk("irq", 32'h0, 32'(irq));
    p.card_detect_pin_b_b = 1'b1;
    pin();
    chk("irq", 32'h1, 32'(irq));
    chk("irq_line", 32'h20, 32'(irq_line));
    rd(8'h10, 8'h08, 2'h0);
    rd(8'h10, 8'h08, 2'h0);
    wr(8'h14, 8'h50, 2'h0);
    rd(8'h10, 8'h00, 2'h0);
    chk("irq", 32'h0, 32'(irq));
    wr(8'h14, 8'h58, 2'h0);
    wr(8'h10, 8'h08, 2'h0);
    rd(8'h10, 8'h00, 2'h0);
    chk("irq", 32'h0, 32'(irq));
  endtask

  task automatic t_ready();
    wr(8'h78, 8'h00, 2'h0);
    wr(8'h14, 8'h54, 2'h0);
    p.ready = 1'b1;
    pin();
    chk("irq", 32'h1, 32'(irq));
    // implicit mode: a status write must not acknowledge
    wr(8'h10, 8'h04, 2'h0);
    rd(8'h10, 8'h04, 2'h0);
    chk("irq", 32'h0, 32'(irq));
    rd(8'h10, 8'h00, 2'h0);
    p.ready = 1'b0;
    pin();
    rd(8'h10, 8'h00, 2'h0);
    wr(8'h14, 8'h50, 2'h0);
    p.ready = 1'b1;
    pin();
    wr(8'h14, 8'h54, 2'h0);
    rd(8'h10, 8'h00, 2'h0);
  endtask

  task automatic t_battery();
    wr(8'h78, 8'h01, 2'h0);
    wr(8'h14, 8'hE3, 2'h0);
    p.low_battery = 1'b1;
    pin();
    rd(8'h10, 8'h02, 2'h0);
    p.battery_fail = 1'b1;
    pin();
    rd(8'h10, 8'h03, 2'h0);
    wr(8'hFC, 8'h03, 2'h0);
    rd(8'hFC, 8'h00, 2'h0);
    rd(8'h10, 8'h00, 2'h0);
    wr(8'h78, 8'h07, 2'h0);
    p.card_change_ring_line_b = 1'b0;
    pin();
    rd(8'h10, 8'h00, 2'h0);
    p.card_change_ring_line_b = 1'b1;
    pin();
    wr(8'h78, 8'h05, 2'h0);
    rd(8'h78, 8'h05, 2'h0);
    p.card_change_ring_line_b = 1'b0;
    p.low_battery = 1'b0;
    pin();
    p.low_battery = 1'b1;
    pin();
    rd(8'h10, 8'h01, 2'h0);
    chk("irq", 32'h1, 32'(irq));
    chk("irq_line", 32'h4000, 32'(irq_line));
    wr(8'h10, 8'h01, 2'h0);
    wr(8'h14, 8'hE2, 2'h0);
    p.card_change_ring_line_b = 1'b1;
    pin();
    p.card_change_ring_line_b = 1'b0;
    pin();
    wr(8'h14, 8'hE3, 2'h0);
    rd(8'h10, 8'h00, 2'h0);
  endtask

  task automatic t_window();
    wr(8'h18, 8'hFF, 2'h0);
    rd(8'h18, 8'hDF, 2'h0);
    @(posedge clk);
    mem_hit <= 5'h11;
    io_hit <= 2'h2;
    maddr <= 26'h1234567;
    repeat (2) @(posedge clk);
    chk("mem_en", 32'h11, 32'(mem_en));
    chk("io_en", 32'h2, 32'(io_en));
    chk("card_addr", 32'h1234567, 32'(caddr));
    wr(8'h18, 8'h01, 2'h0);
    repeat (2) @(posedge clk);
    chk("mem_en", 32'h01, 32'(mem_en));
    chk("io_en", 32'h0, 32'(io_en));
    // hit only in a closed window: address must hold
    mem_hit <= 5'h10;
    maddr <= 26'h2AAAAAA;
    repeat (2) @(posedge clk);
    chk("mem_en", 32'h00, 32'(mem_en));
    chk("card_addr", 32'h1234567, 32'(caddr));
  endtask

  // reset in mid-run after every register was written
  task automatic t_reset();
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    chk("irq_oe", 32'h0, 32'(irq_oe));
    rd(8'h14, 8'h00, 2'h0);
    rd(8'h18, 8'h00, 2'h0);
    rd(8'h10, 8'h00, 2'h0);
  endtask

  // whole run is a few hundred cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      final_report();
    end
  end

  initial
  begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    t_map();
    t_route();
    t_detect();
    t_ready();
    t_battery();
    t_window();
    t_reset();
    final_report();
  end
endmodule // testbench
`default_nettype wire
